// *** rwpm_regs.svh ***
`ifndef RWPM_REGS_SVH
`define RWPM_REGS_SVH
// How it works
// - Low-supply reset after continuous debounce time
// - Release when supply rises; ignore short dips
// - Low-supply enable by option; three thresholds
// - PC over-range or opcode A5H resets, flags
// - Watchdog down counter on RC clock
// - Watchdog enable fixed by code option
// - Status register access restarts watchdog
// - Period select sets overflow period
// - Bit 7 watchdog/over-range flag, software clear
// - Bit 5 power-on flag, only software clears
// - Bit 4 low-supply flag, software or POR clear
// - Bit 3 pin reset flag, software or POR clear
// - Idle gates processor clock, peripherals run
// - Idle needs key 55 then sleep bit
// - Power-down needs key 55 then request bit
// - Interrupt wakes idle after warm-up, clears bits
// - Reset during sleep restores clock, clears bits
// - Power-down stops all clocks except watchdog
// - Both bits set enters power-down, clears both
// - External or comparator interrupt wakes power-down
// - Power control 87H: sleep bit0, power-down bit1
// - Suspend key 8EH, eight bits, resets zero
`define RWPM_ADDR_STATUS   8'hb1
`define RWPM_ADDR_POWER_CONTROL_REGISTER     8'h87
`define RWPM_ADDR_KEY      8'h8e
`define RWPM_KEY_VALUE     8'h55
`define RWPM_BAD_OPCODE    8'ha5
`define RWPM_BIT_WATCHDOG_OVERRANGE_FLAG      7
`define RWPM_BIT_POWERON_CAUSE_FLAG      5
`define RWPM_BIT_LOWSUPPLY_CAUSE_FLAG      4
`define RWPM_BIT_PINF      3
`define RWPM_BIT_IDLE      0
`define RWPM_BIT_PDOWN     1
`define RWPM_CLK_MHZ       25
`define RWPM_DEBOUNCE_US   100
`define RWPM_DEBOUNCE_CYC  (`RWPM_DEBOUNCE_US * `RWPM_CLK_MHZ)
`define RWPM_WARMUP_CYC    16'h0040
`define RWPM_RC_TICKS_MS   16'h0020
`define RWPM_PC_LIMIT      16'h2000
`define RWPM_LEVELS        3
`define RWPM_PERIOD_MSB    2
`endif

// *** rwpm_pkg.sv ***
package rwpm_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rwpm_bus_t;
	typedef struct packed {
		logic        fetch;
		logic [15:0] pc;
		logic [7:0]  opcode;
	} rwpm_fetch_t;
	typedef enum logic [2:0] {
		RWPM_RUN   = 3'b001,
		RWPM_IDLE  = 3'b010,
		RWPM_PDOWN = 3'b100
	} rwpm_mode_t;
endpackage

// *** rwpm_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "rwpm_regs.svh"
module rwpm_top (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Power-on indication and external reset pin
	input  wire logic                 por,
	input  wire logic                 pin_reset,
	// Factory code options
	input  wire logic                 low_supply_option,
	input  wire logic                 watchdog_code_option,
	input  wire logic [1:0]           low_supply_threshold,
	// Analogue comparators, one per threshold level
	input  wire logic [2:0]           supply_low_level,
	// Independent RC oscillator tick
	input  wire logic                 rc_tick,
	// Interrupt wake sources
	input  wire logic [2:0]           external_irq,
	input  wire logic                 comparator_irq,
	input  wire logic                 irq_pending,
	// Instruction fetch monitor
	input  wire rwpm_pkg::rwpm_fetch_t fetch_in,
	// Register port
	input  wire rwpm_pkg::rwpm_bus_t   bus_in,
	output logic [7:0]                rdata,
	// Reset and clock control
	output logic                      sys_reset,
	output logic                      cpu_clk_en,
	output logic                      periph_clk_en,
	output logic                      osc_run
);
	import rwpm_pkg::*;

	// ------------------------------------------------------------
	// Period decoding
	// ------------------------------------------------------------
	function automatic logic [21:0] rwpm_period(input logic [2:0] sel);
		logic [12:0] ms;
		ms = 13'h0001;
		case (sel)
			3'h0: ms = 13'h1000;
			3'h1: ms = 13'h0400;
			3'h2: ms = 13'h0100;
			3'h3: ms = 13'h0080;
			3'h4: ms = 13'h0040;
			3'h5: ms = 13'h0010;
			3'h6: ms = 13'h0004;
			default: ms = 13'h0001;
		endcase
		rwpm_period = 22'(ms * `RWPM_RC_TICKS_MS);
	endfunction

	function automatic logic hit(input rwpm_bus_t b, input logic [7:0] a);
		hit = (b.wr || b.rd) && (b.addr == a);
	endfunction

	function automatic logic wr_hit(input rwpm_bus_t b, input logic [7:0] a);
		wr_hit = b.wr && (b.addr == a);
	endfunction

	// Unmapped addresses read as zero
	function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] st,
			input logic [7:0] pc, input logic [7:0] ky);
		case (a)
			`RWPM_ADDR_STATUS: read_mux = st;
			`RWPM_ADDR_POWER_CONTROL_REGISTER:   read_mux = pc;
			`RWPM_ADDR_KEY:    read_mux = ky;
			default:           read_mux = 8'h0;
		endcase
	endfunction

	logic [7:0]  status_word;
	logic        watchdog_overrange_flag_q;
	logic        poweron_cause_flag_q;
	logic        lowsupply_cause_flag_q;
	logic        pinf_q;
	logic [2:0]  period_q;
	logic [7:0]  power_control_register_q;
	logic [7:0]  key_q;
	logic        key_just_q;
	logic [21:0] wdog_q;
	logic [15:0] deb_q;
	logic        lvr_q;
	logic [15:0] warm_q;
	rwpm_mode_t  mode_q;
	logic        wdog_over;
	logic        pc_overrange_reset;
	logic        supply_low;
	logic        any_reset;
	logic        wake_irq;
	logic        set_power_control_register;
	logic        status_acc;
	logic        status_wr;
	logic        key_wr;
	logic        key_taken;
	logic        key_stale;
	logic        deb_done;
	logic [2:0]  level_low;
	logic [2:0]  reload_sel;
	genvar       lv;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	// Reads kick the watchdog too, so a polling loop keeps it alive
	assign status_acc = hit(bus_in, `RWPM_ADDR_STATUS);
	assign status_wr  = wr_hit(bus_in, `RWPM_ADDR_STATUS);
	assign key_wr     = wr_hit(bus_in, `RWPM_ADDR_KEY);

	// ------------------------------------------------------------
	// Reset sources
	// ------------------------------------------------------------
	// One comparator per level; the option code picks which one counts
	generate
		for (lv = 0; lv < `RWPM_LEVELS; lv++) begin : g_level
			assign level_low[lv] = (low_supply_threshold == 2'(lv)) &&
				supply_low_level[lv];
		end
	endgenerate

	// Threshold code 3 matches no level, so it turns the monitor off
	assign supply_low = low_supply_option && (|level_low);
	assign pc_overrange_reset = fetch_in.fetch && ((fetch_in.pc >= `RWPM_PC_LIMIT) ||
		(fetch_in.opcode == `RWPM_BAD_OPCODE));
	assign wdog_over = watchdog_code_option && rc_tick && (wdog_q == 22'h0);
	assign any_reset = wdog_over || pc_overrange_reset || lvr_q || pin_reset;

	// Debounce restarts on any high sample, so only a continuous dip counts
	assign deb_done = deb_q >= 16'(`RWPM_DEBOUNCE_CYC);

	always_ff @(posedge clock) begin
		if (rst || por || !supply_low) begin
			deb_q <= 16'h0;
		end else if (!deb_done) begin
			deb_q <= deb_q + 16'h1;
		end
	end

	// Reset lasts as long as the supply stays low
	always_ff @(posedge clock) begin
		if (rst || por || !supply_low) begin
			lvr_q <= 1'b0;
		end else if (deb_done) begin
			lvr_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Watchdog on RC ticks
	// ------------------------------------------------------------
	// A kick reloads the live period; a write takes its new period at once
	always_comb begin
		reload_sel = period_q;
		if (rst || por || any_reset) begin
			reload_sel = 3'h0;
		end else if (status_wr) begin
			reload_sel = bus_in.wdata[`RWPM_PERIOD_MSB:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst || por || status_acc || any_reset) begin
			wdog_q <= rwpm_period(reload_sel);
		end else if (rc_tick) begin
			wdog_q <= wdog_q - 22'h1;
		end
	end

	// ------------------------------------------------------------
	// Reset cause register; hardware set wins over software clear
	// ------------------------------------------------------------
	// Bit 6 is unimplemented and always reads zero
	assign status_word = {watchdog_overrange_flag_q, 1'b0, poweron_cause_flag_q, lowsupply_cause_flag_q, pinf_q, period_q};

	// Watchdog or over-range cause
	always_ff @(posedge clock) begin
		if (rst || por) begin
			watchdog_overrange_flag_q <= 1'b0;
		end else if (wdog_over || pc_overrange_reset) begin
			watchdog_overrange_flag_q <= 1'b1;
		end else if (status_wr) begin
			watchdog_overrange_flag_q <= bus_in.wdata[`RWPM_BIT_WATCHDOG_OVERRANGE_FLAG];
		end
	end

	// Power-on cause survives every other reset source
	always_ff @(posedge clock) begin
		if (rst || por) begin
			poweron_cause_flag_q <= 1'b1;
		end else if (status_wr) begin
			poweron_cause_flag_q <= bus_in.wdata[`RWPM_BIT_POWERON_CAUSE_FLAG];
		end
	end

	// Low-supply cause
	always_ff @(posedge clock) begin
		if (rst || por) begin
			lowsupply_cause_flag_q <= 1'b0;
		end else if (lvr_q) begin
			lowsupply_cause_flag_q <= 1'b1;
		end else if (status_wr) begin
			lowsupply_cause_flag_q <= bus_in.wdata[`RWPM_BIT_LOWSUPPLY_CAUSE_FLAG];
		end
	end

	// Pin reset cause
	always_ff @(posedge clock) begin
		if (rst || por) begin
			pinf_q <= 1'b0;
		end else if (pin_reset) begin
			pinf_q <= 1'b1;
		end else if (status_wr) begin
			pinf_q <= bus_in.wdata[`RWPM_BIT_PINF];
		end
	end

	// Period falls back to the longest one on any reset
	always_ff @(posedge clock) begin
		if (rst || por || any_reset) begin
			period_q <= 3'h0;
		end else if (status_wr) begin
			period_q <= bus_in.wdata[`RWPM_PERIOD_MSB:0];
		end
	end

	// ------------------------------------------------------------
	// Suspend key and power control
	// ------------------------------------------------------------
	assign set_power_control_register = wr_hit(bus_in, `RWPM_ADDR_POWER_CONTROL_REGISTER);
	assign wake_irq = (mode_q == RWPM_PDOWN) ? (|external_irq || comparator_irq) :
		irq_pending;

	// Key lives for the one following bus cycle, and one cycle more after each write it unlocks
	assign key_taken = set_power_control_register && key_q == `RWPM_KEY_VALUE && key_just_q;
	assign key_stale = mode_q == RWPM_RUN && !key_just_q && key_q != 8'h0;

	always_ff @(posedge clock) begin
		if (rst || por || any_reset) begin
			key_q <= 8'h0;
		end else if (key_wr) begin
			key_q <= bus_in.wdata;
		end else if (mode_q != RWPM_RUN && wake_irq) begin
			key_q <= 8'h0;
		end else if (key_stale) begin
			key_q <= 8'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || por || any_reset) begin
			key_just_q <= 1'b0;
		end else if (key_wr) begin
			key_just_q <= 1'b1;
		end else if (mode_q != RWPM_RUN && wake_irq) begin
			key_just_q <= 1'b0;
		end else if (mode_q == RWPM_RUN && !key_taken) begin
			key_just_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || por || any_reset) begin
			power_control_register_q <= 8'h0;
		end else if (set_power_control_register) begin
			power_control_register_q <= bus_in.wdata;
			if (!(key_just_q && key_q == `RWPM_KEY_VALUE)) begin
				power_control_register_q[1:0] <= 2'h0;
			end
		end else if (mode_q != RWPM_RUN && wake_irq) begin
			power_control_register_q[1:0] <= 2'h0;
		end
	end

	// ------------------------------------------------------------
	// Mode machine with wake warm-up
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst || por || any_reset) begin
			mode_q <= RWPM_RUN;
			warm_q <= 16'h0;
		end else begin
			case (mode_q)
				RWPM_RUN: begin
					if (warm_q != 16'h0) begin
						warm_q <= warm_q - 16'h1;
					end else if (power_control_register_q[`RWPM_BIT_PDOWN]) begin
						mode_q <= RWPM_PDOWN;
					end else if (power_control_register_q[`RWPM_BIT_IDLE]) begin
						mode_q <= RWPM_IDLE;
					end
				end
				RWPM_IDLE, RWPM_PDOWN: begin
					if (wake_irq) begin
						mode_q <= RWPM_RUN;
						warm_q <= `RWPM_WARMUP_CYC;
					end
				end
				default: mode_q <= RWPM_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs and read port
	// ------------------------------------------------------------
	// Reset request to the rest of the device
	always_ff @(posedge clock) begin
		if (rst) begin
			sys_reset <= 1'b1;
		end else begin
			sys_reset <= por || any_reset;
		end
	end

	// Processor clock waits for the warm-up after any wake
	always_ff @(posedge clock) begin
		if (rst) begin
			cpu_clk_en <= 1'b0;
		end else begin
			cpu_clk_en <= mode_q == RWPM_RUN && warm_q == 16'h0;
		end
	end

	// Peripherals keep running in idle, stop in power-down
	always_ff @(posedge clock) begin
		if (rst) begin
			periph_clk_en <= 1'b0;
		end else begin
			periph_clk_en <= mode_q != RWPM_PDOWN && warm_q == 16'h0;
		end
	end

	// Main oscillator; the watchdog RC source is never stopped here
	always_ff @(posedge clock) begin
		if (rst) begin
			osc_run <= 1'b1;
		end else begin
			osc_run <= mode_q != RWPM_PDOWN;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || !bus_in.rd) begin
			rdata <= 8'h0;
		end else begin
			rdata <= read_mux(bus_in.addr, status_word, power_control_register_q, key_q);
		end
	end
endmodule
`default_nettype wire

// *** rwpm_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module rwpm_checker (
	// Watched ports
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  pin_reset,
	input wire logic [2:0]            external_irq,
	input wire logic                  comparator_irq,
	input wire rwpm_pkg::rwpm_fetch_t fetch_in,
	input wire rwpm_pkg::rwpm_bus_t   bus_in,
	input wire logic                  sys_reset,
	input wire logic                  cpu_clk_en,
	input wire logic                  periph_clk_en,
	input wire logic                  osc_run
);
	import rwpm_pkg::*;
	logic armed_q;
	logic pcw;
	assign pcw = bus_in.wr && bus_in.addr == 8'h87;
	// Only a key write in the bus cycle just before arms the request
	always_ff @(posedge clock) begin
		if (rst || sys_reset)
			armed_q <= 1'b0;
		else
			armed_q <= bus_in.wr && bus_in.addr == 8'h8e && bus_in.wdata == 8'h55;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_badop_reset: assert property (
		fetch_in.fetch && (fetch_in.opcode == 8'ha5 || fetch_in.pc >= 16'h2000)
		|-> ##[1:3] sys_reset) else $error("no over-range reset");
	chk_pin_reset: assert property (
		$rose(pin_reset) |-> ##[1:3] sys_reset) else $error("no pin reset");
	chk_clk_order: assert property (
		cpu_clk_en |-> periph_clk_en) else $error("cpu clock without peripherals");
	chk_pdown_gate: assert property (
		!osc_run |-> !periph_clk_en) else $error("clock runs with oscillator off");
	chk_idle_enter: assert property (
		armed_q && pcw && bus_in.wdata[1:0] == 2'b01
		|-> ##[1:3] (!cpu_clk_en && periph_clk_en)) else $error("idle not entered");
	chk_pd_enter: assert property (
		armed_q && pcw && bus_in.wdata[1]
		|-> ##[1:3] !periph_clk_en) else $error("power-down not entered");
	chk_nokey_run: assert property (
		!armed_q && pcw && cpu_clk_en && !sys_reset && bus_in.wdata[1:0] != 2'b00
		|-> ##2 cpu_clk_en) else $error("sleep without key");
	chk_wake_bound: assert property (
		!osc_run && (|external_irq || comparator_irq)
		|-> ##[1:90] cpu_clk_en) else $error("no wake from power-down");
endmodule
bind rwpm_top rwpm_checker u_chk (.clock, .rst, .pin_reset, .external_irq,
	.comparator_irq, .fetch_in, .bus_in, .sys_reset, .cpu_clk_en, .periph_clk_en, .osc_run);
`default_nettype wire

// *** rwpm_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rwpm_core_model (
	// Clock and register port
	input  wire logic               clock,
	input  wire logic [7:0]         rdata,
	output var rwpm_pkg::rwpm_bus_t bus
);
	import rwpm_pkg::*;
	initial bus = '0;
	task op(input logic w, r, input logic [7:0] a, d);
		bus <= '{a, d, w, r};
		@(posedge clock);
	endtask
	task wr(input logic [7:0] a, d);
		op(1'b1, 1'b0, a, d);
		op(1'b0, 1'b0, a, 8'h00);
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		op(1'b0, 1'b1, a, 8'h00);
		#1 d = rdata;
		op(1'b0, 1'b0, a, 8'h00);
	endtask
	// Idle slots stand in for the no-ops the core must run after a request
	task sleep(input logic [1:0] req);
		op(1'b1, 1'b0, 8'h8e, 8'h55);
		op(1'b1, 1'b0, 8'h87, {6'h00, req});
		repeat (3) op(1'b0, 1'b0, 8'h00, 8'h00);
	endtask
endmodule
`default_nettype wire

// *** reset_watchdog_power_manager_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module reset_watchdog_power_manager_bench;
	import rwpm_pkg::*;
	logic        clock, rst, por, pin_reset, rc_tick, rc_on, irq_pending, comparator_irq;
	logic [2:0]  external_irq, supply_low_level;
	logic [7:0]  rdata, v;
	rwpm_fetch_t fetch_in;
	rwpm_bus_t   bus_in;
	logic        sys_reset, cpu_clk_en, periph_clk_en, osc_run;
	int          fail_count = 0, compares = 0, cycles = 0;
	logic [23:0] rows [4] = '{24'hb1_00_00, 24'hb1_ff_bf, 24'h40_5a_00, 24'hb1_07_07};
	rwpm_top dut (.clock, .rst, .por, .pin_reset, .low_supply_option(1'b1),
		.watchdog_code_option(1'b1), .low_supply_threshold(2'b00), .supply_low_level,
		.rc_tick, .external_irq, .comparator_irq, .irq_pending, .fetch_in, .bus_in,
		.rdata, .sys_reset, .cpu_clk_en, .periph_clk_en, .osc_run);
	rwpm_core_model core (.clock, .rdata, .bus(bus_in));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		rc_tick <= rc_on && !rc_tick;
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			report_and_stop;
		end
	end
	task chk(input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task settle;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 3000 && cpu_clk_en !== 1'b1; i++)
			@(posedge clock);
	endtask
	task report_and_stop;
		$display("compares=%0d mismatches=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{rst, por, pin_reset, rc_on, rc_tick, irq_pending, comparator_irq} = 7'h60;
		{external_irq, supply_low_level, fetch_in} = '0;
		repeat (20) @(posedge clock);
		{rst, por} <= 2'b00;
		settle;
		foreach (rows[i]) begin
			core.wr(rows[i][23:16], rows[i][15:8]);
			core.rd(rows[i][23:16], v);
			chk(v, rows[i][7:0]);
		end
		$display("table done");
		core.wr(8'hb1, 8'h25);
		pin_reset <= 1'b1;
		repeat (3) @(posedge clock);
		pin_reset <= 1'b0;
		settle;
		core.rd(8'hb1, v);
		chk(v, 8'h28);
		$display("pin done");
		core.wr(8'hb1, 8'h00);
		for (int n = 2000; n <= 2700; n += 700) begin
			supply_low_level <= 3'b111;
			repeat (n) @(posedge clock);
			supply_low_level <= 3'b000;
			settle;
			core.rd(8'hb1, v);
			chk(v, n > 2500 ? 8'h10 : 8'h00);
		end
		$display("low supply done");
		for (int k = 0; k < 2; k++) begin
			core.wr(8'hb1, 8'h00);
			fetch_in <= {1'b1, k ? 16'h2000 : 16'h0010, k ? 8'h00 : 8'ha5};
			@(posedge clock);
			fetch_in <= '0;
			settle;
			core.rd(8'hb1, v);
			chk(v, 8'h80);
		end
		$display("over-range done");
		core.wr(8'hb1, 8'h07);
		rc_on <= 1'b1;
		repeat (5) begin
			repeat (40) @(posedge clock);
			core.rd(8'hb1, v);
			chk(v, 8'h07);
		end
		repeat (200) @(posedge clock);
		rc_on <= 1'b0;
		settle;
		core.rd(8'hb1, v);
		chk(v, 8'h80);
		$display("watchdog done");
		core.sleep(2'b01);
		chk({6'h00, cpu_clk_en, periph_clk_en}, 8'h01);
		irq_pending <= 1'b1;
		settle;
		irq_pending <= 1'b0;
		chk({6'h00, cpu_clk_en, periph_clk_en}, 8'h03);
		for (int k = 0; k < 4; k++) begin
			core.sleep(k ? 2'b10 : 2'b11);
			chk({6'h00, cpu_clk_en, periph_clk_en}, 8'h00);
			{comparator_irq, external_irq} <= 4'h1 << k;
			settle;
			{comparator_irq, external_irq} <= 4'h0;
			repeat (4) @(posedge clock);
			chk({6'h00, cpu_clk_en, periph_clk_en}, 8'h03);
			core.rd(8'h87, v);
			chk(v & 8'h03, 8'h00);
		end
		$display("sleep done");
		core.wr(8'h87, 8'h01);
		repeat (3) @(posedge clock);
		chk({7'h00, cpu_clk_en}, 8'h01);
		rst <= 1'b1;
		por <= 1'b1;
		repeat (2) @(posedge clock);
		{rst, por} <= 2'b00;
		settle;
		core.rd(8'hb1, v);
		chk(v, 8'h20);
		core.rd(8'h8e, v);
		chk(v, 8'h00);
		$display("reset done");
		report_and_stop;
	end
endmodule
`default_nettype wire
